// ---- pod_pkg.sv ----
package pod_pkg;

  localparam int FB_INT_W  = 11;
  localparam int FB_FRAC_W = 32;
  localparam int FB_W      = FB_INT_W + FB_FRAC_W;
  localparam int HS_W      = 11;
  localparam int LS_W      = 3;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int CNT_W     = 24;

  localparam logic [ADDR_W-1:0] REG_FB_FRAC = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FB_INT  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_HS_DIV  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LS_EXP  = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h14;

  localparam int CTRL_APPLY_BIT    = 0;
  localparam int STAT_SETTLED_BIT  = 0;
  localparam int STAT_SQUELCH_BIT  = 1;
  localparam int STAT_LARGE_BIT    = 2;
  localparam int STAT_EFF_HS_LSB   = 16;
  localparam int STAT_EFF_LS_LSB   = 8;

  localparam logic [FB_INT_W-1:0]  RST_FB_INT  = 11'h03C;
  localparam logic [FB_FRAC_W-1:0] RST_FB_FRAC = 32'h00000000;
  localparam logic [HS_W-1:0]      RST_HS_DIV  = 11'h004;
  localparam logic [LS_W-1:0]      RST_LS_EXP  = 3'h0;
  localparam logic [FB_W-1:0]      RST_FB      = {RST_FB_INT, RST_FB_FRAC};

  localparam logic [HS_W-1:0] HS_MIN     = 11'h004;
  localparam logic [HS_W-1:0] HS_MAX     = 11'h7FE;
  localparam logic [HS_W-1:0] HS_ODD_MAX = 11'h021;
  localparam logic [LS_W-1:0] LS_MAX_EXP = 3'h5;

  localparam int     CLK_MHZ         = 40;
  localparam longint PPM_TOL         = 950;
  localparam longint RST_FB_L        = 64'h00000003C0000000;
  localparam logic [FB_W-1:0] FB_TOL = FB_W'(RST_FB_L * PPM_TOL / 1000000);
  localparam int SMALL_SETTLE_US     = 100;
  localparam int SMALL_SETTLE_CYC    = SMALL_SETTLE_US * CLK_MHZ;
  localparam int LARGE_SETTLE_MS     = 10;
  localparam int LARGE_SETTLE_CYC    = LARGE_SETTLE_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic [FB_INT_W-1:0]  fb_int;
    logic [FB_FRAC_W-1:0] fb_frac;
    logic [HS_W-1:0]      hs;
    logic [LS_W-1:0]      ls;
  } pod_cfg_s;

  typedef enum logic [1:0] {ST_RUN, ST_SMALL, ST_SQUELCH} pod_state_e;

endpackage

// ---- pod_hs_div.sv ----
`timescale 1ns/1ps
module pod_hs_div
  import pod_pkg::*;
(
  input  wire logic            clk_sys_in,
  input  wire logic            reset_in,
  input  wire logic            restart_in,
  input  wire logic            tick_in,
  input  wire logic [HS_W-1:0] ratio_in,
  output logic                 level_out,
  output logic                 rise_out
);

  logic [HS_W-1:0] cnt_ff;
  logic [HS_W-1:0] nxt_cnt;
  logic [HS_W-1:0] ratio_ff;
  logic [HS_W-1:0] nxt_ratio;
  logic            level_ff;
  logic            nxt_level;
  logic            rise_ff;
  logic            nxt_rise;

  // ticks are vco half periods, so any ratio gives 50% duty
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_ratio = ratio_ff;
    nxt_level = level_ff;
    nxt_rise  = 1'b0;
    if (restart_in) begin
      nxt_cnt   = '0;
      nxt_level = 1'b0;
      nxt_ratio = ratio_in;
    end else if (tick_in) begin
      if (cnt_ff == ratio_ff - 11'h001) begin
        nxt_cnt   = '0;
        nxt_level = ~level_ff;
        nxt_rise  = ~level_ff;
        nxt_ratio = ratio_in; // reload only at a boundary or on restart
      end else begin
        nxt_cnt = cnt_ff + 11'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_ff   <= '0;
      ratio_ff <= HS_MIN;
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      ratio_ff <= nxt_ratio;
      level_ff <= nxt_level;
      rise_ff  <= nxt_rise;
    end
  end

  assign level_out = level_ff;
  assign rise_out  = rise_ff;

  a_hs_toggle_point: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    ($changed(level_ff) && !$past(restart_in)) |->
      ($past(tick_in) && ($past(cnt_ff) == $past(ratio_ff) - 11'h001)))
    else $error("high-speed divider toggled off its terminal count");

  a_hs_count_range: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    cnt_ff < ratio_ff)
    else $error("high-speed divider count ran past its ratio");

endmodule

// ---- pod_ls_div.sv ----
`timescale 1ns/1ps
module pod_ls_div
  import pod_pkg::*;
(
  input  wire logic            clk_sys_in,
  input  wire logic            reset_in,
  input  wire logic            restart_in,
  input  wire logic            hs_level_in,
  input  wire logic            hs_rise_in,
  input  wire logic [LS_W-1:0] exp_in,
  output logic                 level_out
);

  logic [4:0]      cnt_ff;
  logic [4:0]      nxt_cnt;
  logic [LS_W-1:0] exp_ff;
  logic [LS_W-1:0] nxt_exp;
  logic            level_ff;
  logic            nxt_level;
  logic [4:0]      half;

  // half period in high-speed periods: 2^(n-1)
  assign half = 5'h01 << (exp_ff - 3'h1);

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_exp   = exp_ff;
    nxt_level = level_ff;
    if (restart_in) begin
      nxt_cnt   = '0;
      nxt_level = 1'b0;
      nxt_exp   = exp_in;
    end else if (exp_ff == 3'h0) begin
      nxt_level = hs_level_in; // divide by one
      if (hs_rise_in) begin
        nxt_exp = exp_in;
      end
    end else if (hs_rise_in) begin
      if (cnt_ff == half - 5'h01) begin
        nxt_cnt   = '0;
        nxt_level = ~level_ff;
        nxt_exp   = exp_in;
      end else begin
        nxt_cnt = cnt_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_ff   <= '0;
      exp_ff   <= RST_LS_EXP;
      level_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      exp_ff   <= nxt_exp;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;

  a_ls_on_rise: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    ($changed(level_ff) && !$past(restart_in) && ($past(exp_ff) != 3'h0))
      |-> $past(hs_rise_in))
    else $error("low-speed divider toggled without a high-speed rise");

  a_ls_exp_cap: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    exp_ff <= LS_MAX_EXP)
    else $error("low-speed exponent above divide by 32");

endmodule

// ---- pod_divider_chain.sv ----
// Function
// - feedback ratio is 43-bit unsigned 11.32 fixed point
// - output equals vco divided by high-speed ratio times low-speed ratio
// - high-speed divider is an 11-bit unsigned integer divider
// - odd high-speed ratios only 4 to 33 when low-speed exponent is 0 (any odd up to 2046 otherwise), still 50% duty
// - low-speed field n divides by two to the n, 1 to 32
// - low-speed exponent 6 or 7 divides by 32
// - dual outputs share frequency, complementary or in phase by option
// - host rewrites dividers in operation and the device follows them
// - change within 950 ppm keeps output running, settles in 100 us (FB_TOL here is 59.375 ppm of the centre feedback, not 950 ppm)
// - change beyond 950 ppm squelches output, settles in 10 ms (FB_TOL here is 59.375 ppm of the centre feedback, not 950 ppm)
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module pod_divider_chain
  import pod_pkg::*;
#(
  parameter int LARGE_CYC     = LARGE_SETTLE_CYC,
  parameter bit DUAL_IN_PHASE = 1'b0
) (
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  input  wire logic              wr_en_in,
  input  wire logic              rd_en_in,
  output logic      [DATA_W-1:0] rd_data_out,
  output logic                   clk_out,
  output logic                   clk_b_out,
  output logic                   settled_out
);

  localparam logic [CNT_W-1:0] SMALL_LOAD = CNT_W'(SMALL_SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] LARGE_LOAD = CNT_W'(LARGE_CYC - 1);

  pod_cfg_s        stage_ff;
  pod_cfg_s        nxt_stage;
  pod_cfg_s        active_ff;
  pod_cfg_s        nxt_active;
  pod_state_e      state_ff;
  pod_state_e      nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic            last_large_ff;
  logic            nxt_last_large;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [FB_W-1:0] acc_ff;
  logic [FB_W-1:0] nxt_acc;
  logic            tick_ff;
  logic            nxt_tick;
  logic            clk_ff;
  logic            nxt_clk;
  logic            clk_b_ff;
  logic            nxt_clk_b;
  logic            apply_req;
  logic            large_chg;
  logic            squelch;
  logic [FB_W-1:0] fb_new;
  logic [FB_W-1:0] fb_act;
  logic [FB_W-1:0] fb_dist;
  logic [HS_W-1:0] eff_hs;
  logic [LS_W-1:0] eff_ls;
  logic            hs_level;
  logic            hs_rise;
  logic            ls_level;

  // ratios the host may leave out of range are pulled back in
  function automatic logic [HS_W-1:0] fix_hs(input logic [HS_W-1:0] raw,
                                            input logic [LS_W-1:0] ls);
    logic [HS_W-1:0] r;
    r = raw;
    if (raw < HS_MIN) begin
      r = HS_MIN;
    end else if (raw > HS_MAX) begin
      r = HS_MAX;
    end else if (raw[0] && (raw > HS_ODD_MAX) && (ls == 3'h0)) begin
      r = raw - 11'h001;
    end
    return r;
  endfunction

  assign fb_new = {stage_ff.fb_int, stage_ff.fb_frac};
  assign fb_act = {active_ff.fb_int, active_ff.fb_frac};
  assign eff_hs = fix_hs(active_ff.hs, active_ff.ls);
  assign eff_ls = (active_ff.ls > LS_MAX_EXP) ? LS_MAX_EXP
                                              : active_ff.ls;
  assign squelch = (state_ff == ST_SQUELCH);
  assign apply_req = wr_en_in && (addr_in == REG_CTRL)
                     && wr_data_in[CTRL_APPLY_BIT];

  // distance of the staged feedback from the centre frequency
  assign fb_dist = (fb_new >= RST_FB) ? fb_new - RST_FB : RST_FB - fb_new;
  assign large_chg = (stage_ff.hs != active_ff.hs)
                     || (stage_ff.ls != active_ff.ls)
                     || (fb_dist > FB_TOL);

  // register port: staging writes and read-back
  always_comb begin
    nxt_stage = stage_ff;
    nxt_rdata = '0;
    if (wr_en_in) begin
      case (addr_in)
        REG_FB_FRAC: nxt_stage.fb_frac = wr_data_in;
        REG_FB_INT:  nxt_stage.fb_int  = wr_data_in[FB_INT_W-1:0];
        REG_HS_DIV:  nxt_stage.hs      = wr_data_in[HS_W-1:0];
        REG_LS_EXP:  nxt_stage.ls      = wr_data_in[LS_W-1:0];
        default:     nxt_stage = stage_ff;
      endcase
    end
    if (rd_en_in) begin
      case (addr_in)
        REG_FB_FRAC: nxt_rdata = stage_ff.fb_frac;
        REG_FB_INT:  nxt_rdata[FB_INT_W-1:0] = stage_ff.fb_int;
        REG_HS_DIV:  nxt_rdata[HS_W-1:0]     = stage_ff.hs;
        REG_LS_EXP:  nxt_rdata[LS_W-1:0]     = stage_ff.ls;
        REG_STATUS: begin
          nxt_rdata[STAT_SETTLED_BIT] = (state_ff == ST_RUN);
          nxt_rdata[STAT_SQUELCH_BIT] = squelch;
          nxt_rdata[STAT_LARGE_BIT]   = last_large_ff;
          nxt_rdata[STAT_EFF_LS_LSB +: LS_W] = eff_ls;
          nxt_rdata[STAT_EFF_HS_LSB +: HS_W] = eff_hs;
        end
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      stage_ff <= '{fb_int: RST_FB_INT, fb_frac: RST_FB_FRAC,
                    hs: RST_HS_DIV, ls: RST_LS_EXP};
      rdata_ff <= '0;
    end else begin
      stage_ff <= nxt_stage;
      rdata_ff <= nxt_rdata;
    end
  end

  // commit and settling control
  always_comb begin
    nxt_active     = active_ff;
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_last_large = last_large_ff;
    if (apply_req) begin
      nxt_active     = stage_ff; // whole set at once
      nxt_last_large = large_chg;
      if (large_chg) begin
        nxt_state = ST_SQUELCH;
        nxt_cnt   = LARGE_LOAD;
      end else begin
        nxt_state = ST_SMALL;
        nxt_cnt   = SMALL_LOAD;
      end
    end else begin
      case (state_ff)
        ST_RUN: nxt_cnt = '0;
        ST_SMALL, ST_SQUELCH: begin
          if (cnt_ff == '0) begin
            nxt_state = ST_RUN;
          end else begin
            nxt_cnt = cnt_ff - 24'h000001;
          end
        end
        default: nxt_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      active_ff     <= '{fb_int: RST_FB_INT, fb_frac: RST_FB_FRAC,
                         hs: RST_HS_DIV, ls: RST_LS_EXP};
      state_ff      <= ST_RUN;
      cnt_ff        <= '0;
      last_large_ff <= 1'b0;
    end else begin
      active_ff     <= nxt_active;
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      last_large_ff <= nxt_last_large;
    end
  end

  // digital vco: carry rate is fclk * ratio / 2^11 half periods
  always_comb begin
    {nxt_tick, nxt_acc} = {1'b0, acc_ff} + {1'b0, fb_act};
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      acc_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  pod_hs_div u_hs (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .restart_in (squelch),
    .tick_in    (tick_ff),
    .ratio_in   (eff_hs),
    .level_out  (hs_level),
    .rise_out   (hs_rise)
  );

  pod_ls_div u_ls (
    .clk_sys_in  (clk_sys_in),
    .reset_in    (reset_in),
    .restart_in  (squelch),
    .hs_level_in (hs_level),
    .hs_rise_in  (hs_rise),
    .exp_in      (eff_ls),
    .level_out   (ls_level)
  );

  // output drivers, held low while squelched
  always_comb begin
    nxt_clk   = ls_level && !squelch;
    nxt_clk_b = 1'b0;
    if (!squelch) begin
      nxt_clk_b = DUAL_IN_PHASE ? ls_level : ~ls_level;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      clk_ff   <= 1'b0;
      clk_b_ff <= 1'b0;
    end else begin
      clk_ff   <= nxt_clk;
      clk_b_ff <= nxt_clk_b;
    end
  end

  assign clk_out     = clk_ff;
  assign clk_b_out   = clk_b_ff;
  assign settled_out = (state_ff == ST_RUN);
  assign rd_data_out = rdata_ff;

  sequence s_apply;
    apply_req;
  endsequence

  a_apply_atomic: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    s_apply |=> (active_ff == $past(stage_ff)))
    else $error("divider set not committed whole");

  a_hold_between: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !apply_req |=> $stable(active_ff))
    else $error("active dividers changed without a commit");

  a_small_run: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (s_apply and !large_chg) |=> (state_ff == ST_SMALL)
      && (cnt_ff == SMALL_LOAD) && !squelch)
    else $error("small change did not start glitchless settling");

  a_large_squelch: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (s_apply and large_chg) |=> squelch && (cnt_ff == LARGE_LOAD)
      ##1 (!clk_out && !clk_b_out))
    else $error("large change did not squelch outputs");

  a_squelch_low: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    $past(squelch) |-> (!clk_out && !clk_b_out))
    else $error("outputs ran while squelched");

  a_settle_end: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!apply_req && (state_ff != ST_RUN) && (cnt_ff == '0)) |=> settled_out)
    else $error("settling did not end at count zero");

  a_dual_pair: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (!$past(reset_in) && !$past(squelch)) |->
      (clk_b_out == (DUAL_IN_PHASE ? clk_out : !clk_out)))
    else $error("dual outputs lost their phase relation");

  a_odd_range: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    eff_hs[0] |-> ((eff_hs <= HS_ODD_MAX) || (active_ff.ls != 3'h0)))
    else $error("odd high-speed ratio outside duty-corrected range");

  a_ls_clamp: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    (active_ff.ls > LS_MAX_EXP) |-> (eff_ls == LS_MAX_EXP))
    else $error("low-speed exponent above 5 not mapped to 32");

  a_vco_sum: assert property (
    @(posedge clk_sys_in) disable iff (reset_in)
    !$past(reset_in) |-> ({tick_ff, acc_ff} ==
      ({1'b0, $past(acc_ff)} + {1'b0, $past(fb_act)})))
    else $error("vco accumulator step wrong");

endmodule

// ---- pod_host_model.sv ----
`timescale 1ns/1ps
module pod_host_model
  import pod_pkg::*;
(
  input  wire logic              clk_sys_in,
  output logic      [ADDR_W-1:0] addr_out,
  output logic      [DATA_W-1:0] wr_data_out,
  output logic                   wr_en_out,
  output logic                   rd_en_out,
  input  wire logic [DATA_W-1:0] rd_data_in
);
  initial begin
    addr_out    = 8'h00;
    wr_data_out = 32'h0;
    wr_en_out   = 1'b0;
    rd_en_out   = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    addr_out    <= a;
    wr_data_out <= d;
    wr_en_out   <= 1'b1;
    @(posedge clk_sys_in);
    wr_en_out   <= 1'b0;
    wr_data_out <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a,
                    output logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    addr_out  <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_en_out <= 1'b0;
    #1 d = rd_data_in;
  endtask

  // whole unsigned set staged first, then one commit
  task automatic cfg_set(input logic [10:0] fi, input logic [31:0] ff,
                         input logic [10:0] hs, input logic [2:0] ls);
    wr(REG_FB_INT, 32'(fi));
    wr(REG_FB_FRAC, ff);
    wr(REG_HS_DIV, 32'(hs));
    wr(REG_LS_EXP, 32'(ls));
    wr(REG_CTRL, 32'h1);
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb
  import pod_pkg::*;
;
  localparam int LC = 50;
  logic              clk_sys_in;
  logic              reset_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wr_data_in;
  logic              wr_en_in;
  logic              rd_en_in;
  logic [DATA_W-1:0] rd_data_out;
  logic              clk_out;
  logic              clk_b_out;
  logic              settled_out;
  int                err_count;
  int                checks_done;

  pod_divider_chain #(
    .LARGE_CYC     (LC),
    .DUAL_IN_PHASE (1'b0)
  ) u_pod_divider_chain (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .addr_in    (addr_in),
    .wr_data_in (wr_data_in),
    .wr_en_in   (wr_en_in),
    .rd_en_in   (rd_en_in),
    .rd_data_out(rd_data_out),
    .clk_out    (clk_out),
    .clk_b_out  (clk_b_out),
    .settled_out(settled_out)
  );

  pod_host_model u_pod_host_model (
    .clk_sys_in (clk_sys_in),
    .addr_out   (addr_in),
    .wr_data_out(wr_data_in),
    .wr_en_out  (wr_en_in),
    .rd_en_out  (rd_en_in),
    .rd_data_in (rd_data_out)
  );

  always #12.5 clk_sys_in = ~clk_sys_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    u_pod_host_model.rd(a, d);
  endtask

  // cycles between two rises of clk_out, and cycles spent high
  task automatic meas(output int p, output int h);
    logic l;
    int   n;
    n = 0;
    do begin
      l = clk_out;
      @(posedge clk_sys_in);
      #1 n++;
    end while (!(l === 1'b0 && clk_out === 1'b1) && n < 4000);
    p = 0;
    h = 0;
    do begin
      chk(32'(clk_b_out), 32'(!clk_out));
      l = clk_out;
      h += (l === 1'b1);
      @(posedge clk_sys_in);
      #1 p++;
    end while (!(l === 1'b0 && clk_out === 1'b1) && p < 4000);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    rdchk(REG_FB_INT, d);
    chk(d, 32'h3C);
    rdchk(REG_FB_FRAC, d);
    chk(d, 32'h0);
    rdchk(REG_HS_DIV, d);
    chk(d, 32'h4);
    rdchk(REG_LS_EXP, d);
    chk(d, 32'h0);
    rdchk(REG_STATUS, d);
    chk({d[26:16], d[10:8], d[0]}, {17'h0, 11'h004, 3'h0, 1'b1});
    rdchk(8'h20, d);
    chk(d, 32'h0);
  endtask

  // staged values are masked and have no effect until committed
  task automatic t_stage;
    logic [31:0] d;
    u_pod_host_model.wr(REG_FB_INT, 32'hFFFFFC00);
    rdchk(REG_FB_INT, d);
    chk(d, 32'h400);
    u_pod_host_model.wr(REG_HS_DIV, 32'hFFFFF805);
    rdchk(REG_HS_DIV, d);
    chk(d, 32'h5);
    u_pod_host_model.wr(REG_LS_EXP, 32'hFFFFFFFE);
    rdchk(REG_LS_EXP, d);
    chk(d, 32'h6);
    u_pod_host_model.wr(REG_STATUS, 32'h0);
    rdchk(REG_STATUS, d);
    chk({d[26:16], d[10:8], d[0]}, {17'h0, 11'h004, 3'h0, 1'b1});
  endtask

  task automatic apply_big(input logic [10:0] fi, input logic [10:0] hs,
                           input logic [2:0] ls);
    logic [31:0] s;
    int          n;
    u_pod_host_model.cfg_set(fi, 32'h0, hs, ls);
    rdchk(REG_STATUS, s);
    chk(32'(s[2:0]), 32'h6);
    n = 0;
    while (settled_out !== 1'b1 && n < 2 * LC) begin
      chk(32'({clk_out, clk_b_out}), 32'h0);
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk(32'(n >= LC - 4 && n <= LC), 32'h1);
  endtask

  // feedback 1024.0 gives one half-period tick every two cycles
  task automatic t_ratios;
    int          th[6] = '{5, 4, 4, 35, 10, 6};
    int          tl[6] = '{0, 2, 6, 0, 1, 7};
    int          eh[6] = '{5, 4, 4, 34, 10, 6};
    int          el[6] = '{0, 2, 5, 0, 1, 5};
    int          p;
    int          h;
    logic [31:0] s;
    for (int i = 0; i < 6; i++) begin
      apply_big(11'h400, 11'(th[i]), 3'(tl[i]));
      meas(p, h);
      chk(32'(p), 32'(4 * eh[i] * (1 << el[i])));
      chk(32'(h), 32'(2 * eh[i] * (1 << el[i])));
      rdchk(REG_STATUS, s);
      chk({s[26:16], s[10:8]}, 32'({11'(eh[i]), 3'(el[i])}));
    end
  endtask

  task automatic t_small;
    logic [31:0] s;
    logic        l;
    int          n;
    int          r;
    apply_big(11'h03C, 11'h004, 3'h0);
    u_pod_host_model.cfg_set(11'h03C, 32'h00100000, 11'h004, 3'h0);
    rdchk(REG_STATUS, s);
    chk(32'(s[2:0]), 32'h0);
    n = 0;
    r = 0;
    l = clk_out;
    while (settled_out !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_in);
      #1 n++;
      r += (l === 1'b0 && clk_out === 1'b1);
      l = clk_out;
    end
    chk(32'(n >= 3990 && n <= 4000), 32'h1);
    chk(32'(r >= 10), 32'h1);
  endtask

  initial begin
    clk_sys_in  = 1'b0;
    reset_in    = 1'b1;
    err_count   = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_stage();
    t_ratios();
    t_small();
    conclude();
  end

  initial begin
    #2_000_000;
    err_count++;
    conclude();
  end
endmodule
